// ==== osr_pkg.sv ====
// constants and helpers shared by the status readback block
package osr_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CONV_W = 10;
   localparam int unsigned MON_W = 8;

   // register numbers, used directly as read addresses
   localparam logic [5:0] REG_CONV_UPPER = 6'h28;
   localparam logic [5:0] REG_CONV_LOWER = 6'h29;
   localparam logic [5:0] REG_RX_STATUS = 6'h2A;
   localparam logic [5:0] REG_TX_STATUS = 6'h2B;
   localparam logic [5:0] REG_ADJ_FIRST = 6'h2C;
   localparam logic [5:0] REG_ADJ_LAST = 6'h37;

   // field positions
   localparam int unsigned RX_LIVE_BIT = 5;
   localparam int unsigned RX_STICKY_BIT = 4;
   localparam int unsigned TX_FAULT_BIT = 5;
   localparam int unsigned TX_DRIVER_DISABLED_FLAG_BIT = 4;
   localparam int unsigned RCLR_RSVD_BIT = 6;

   // values after reset, and the value that reserved bits read
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [9:0] RST_CONV = 10'h000;
   localparam logic [7:0] RSVD_READ = 8'h00;

   typedef logic [7:0] osr_byte_t;

   // fault when the digital monitor is selected and the level reaches the threshold
   function automatic logic osr_reaches(input logic sel, input logic [7:0] level,
                                        input logic [7:0] thresh);
      osr_reaches = sel && (level >= thresh);
   endfunction
endpackage

// ==== osr_fault_if.sv ====
// transmit fault monitor signals between the readback core and the monitor
`timescale 1ns/100ps
interface osr_fault_if;
   logic [7:0] bias_level;
   logic [7:0] pd_level;
   logic [7:0] bias_fault_threshold;
   logic [7:0] power_fault_threshold;
   logic digital_bias_monitor_select;
   logic digital_photodiode_monitor_select;
   logic fault_clear;
   logic fault_detect;
   logic tx_fault_flag;
   logic tx_driver_disabled_flag;

   modport mon (
      input bias_level,
      input pd_level,
      input bias_fault_threshold,
      input power_fault_threshold,
      input digital_bias_monitor_select,
      input digital_photodiode_monitor_select,
      input fault_clear,
      output fault_detect,
      output tx_fault_flag,
      output tx_driver_disabled_flag
   );

   modport core (
      output bias_level,
      output pd_level,
      output bias_fault_threshold,
      output power_fault_threshold,
      output digital_bias_monitor_select,
      output digital_photodiode_monitor_select,
      output fault_clear,
      input fault_detect,
      input tx_fault_flag,
      input tx_driver_disabled_flag
   );
endinterface

// ==== osr_fault_mon.sv ====
// transmit fault detector with latched fault and driver disable
`timescale 1ns/100ps
module osr_fault_mon (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   osr_fault_if.mon fm
);
   logic bias_hit;
   logic pd_hit;
   logic fault_r;
   logic fault_nxt;

   assign bias_hit = osr_pkg::osr_reaches(fm.digital_bias_monitor_select,
                                          fm.bias_level, fm.bias_fault_threshold);
   assign pd_hit = osr_pkg::osr_reaches(fm.digital_photodiode_monitor_select,
                                        fm.pd_level, fm.power_fault_threshold);
   assign fm.fault_detect = bias_hit | pd_hit;

   // a new detection wins over a clear in the same cycle
   assign fault_nxt = fm.fault_detect | (fault_r & ~fm.fault_clear);

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         fault_r <= 1'b0;
      end
      else
      begin
         fault_r <= fault_nxt;
      end
   end

   assign fm.tx_fault_flag = fault_r;
   assign fm.tx_driver_disabled_flag = fault_r;
endmodule

// ==== osr_status_regs.sv ====
// read-only status and converter readback register group
`timescale 1ns/100ps
module osr_status_regs (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_rd_en,
   input wire logic [5:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_conv_valid,
   input wire logic [9:0] i_conv_result,
   input wire logic i_rx_signal_lost,
   input wire logic [7:0] i_bias_level,
   input wire logic [7:0] i_pd_level,
   input wire logic [7:0] i_bias_fault_threshold,
   input wire logic [7:0] i_power_fault_threshold,
   input wire logic i_digital_bias_monitor_select,
   input wire logic i_digital_photodiode_monitor_select,
   input wire logic i_fault_clear,
   output logic o_tx_fault,
   output logic o_tx_driver_disabled,
   output logic o_rx_signal_lost_sticky
);
   osr_fault_if fault_bus ();

   logic [9:0] conv_r;
   logic [9:0] conv_nxt;
   logic [1:0] lower_hold_r;
   logic [1:0] lower_hold_nxt;
   logic lower_hold_vld_r;
   logic lower_hold_vld_nxt;
   logic rx_signal_lost_live_r;
   logic rx_signal_lost_sticky_r;
   logic rx_signal_lost_sticky_nxt;
   logic los_rise;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic rd_valid_r;

   logic hit_upper;
   logic hit_lower;
   logic hit_rx;
   logic hit_tx;
   logic hit_adj;
   logic [7:0] upper_byte;
   logic [7:0] lower_byte;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic [1:0] lower_bits;

   // fault monitor hookup
   assign fault_bus.bias_level = i_bias_level;
   assign fault_bus.pd_level = i_pd_level;
   assign fault_bus.bias_fault_threshold = i_bias_fault_threshold;
   assign fault_bus.power_fault_threshold = i_power_fault_threshold;
   assign fault_bus.digital_bias_monitor_select = i_digital_bias_monitor_select;
   assign fault_bus.digital_photodiode_monitor_select = i_digital_photodiode_monitor_select;
   assign fault_bus.fault_clear = i_fault_clear;

   osr_fault_mon u_fault_mon (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .fm(fault_bus.mon)
   );

   // address decode
   assign hit_upper = i_rd_en && (i_rd_addr == osr_pkg::REG_CONV_UPPER);
   assign hit_lower = i_rd_en && (i_rd_addr == osr_pkg::REG_CONV_LOWER);
   assign hit_rx = i_rd_en && (i_rd_addr == osr_pkg::REG_RX_STATUS);
   assign hit_tx = i_rd_en && (i_rd_addr == osr_pkg::REG_TX_STATUS);
   assign hit_adj = i_rd_en && (i_rd_addr >= osr_pkg::REG_ADJ_FIRST)
                    && (i_rd_addr <= osr_pkg::REG_ADJ_LAST);

   // conversion capture, whole word at once
   assign conv_nxt = i_conv_valid ? i_conv_result : conv_r;

   // freeze low bits when upper is read
   assign lower_hold_nxt = hit_upper ? conv_r[1:0] : lower_hold_r;
   assign lower_hold_vld_nxt = hit_upper | (lower_hold_vld_r & ~hit_lower);
   assign lower_bits = lower_hold_vld_r ? lower_hold_r : conv_r[1:0];

   assign upper_byte = conv_r[9:2];
   assign lower_byte = {6'h00, lower_bits};

   // sticky set on rising live loss
   assign los_rise = i_rx_signal_lost & ~rx_signal_lost_live_r;
   assign rx_signal_lost_sticky_nxt = los_rise | (rx_signal_lost_sticky_r & ~hit_rx);

   always_comb
   begin
      rx_byte = osr_pkg::RSVD_READ;
      rx_byte[osr_pkg::RX_LIVE_BIT] = rx_signal_lost_live_r;
      rx_byte[osr_pkg::RX_STICKY_BIT] = rx_signal_lost_sticky_r;
   end

   always_comb
   begin
      tx_byte = osr_pkg::RSVD_READ;
      tx_byte[osr_pkg::TX_FAULT_BIT] = fault_bus.tx_fault_flag;
      tx_byte[osr_pkg::TX_DRIVER_DISABLED_FLAG_BIT] = fault_bus.tx_driver_disabled_flag;
   end

   // read data select; unmapped and reserved addresses read zero
   always_comb
   begin
      rd_data_nxt = osr_pkg::RSVD_READ;
      if (hit_upper)
      begin
         rd_data_nxt = upper_byte;
      end
      else if (hit_lower)
      begin
         rd_data_nxt = lower_byte;
      end
      else if (hit_rx)
      begin
         rd_data_nxt = rx_byte;
      end
      else if (hit_tx)
      begin
         rd_data_nxt = tx_byte;
      end
      else if (hit_adj)
      begin
         rd_data_nxt = osr_pkg::RSVD_READ;
      end
      else
      begin
         rd_data_nxt = osr_pkg::RSVD_READ;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         conv_r <= osr_pkg::RST_CONV;
         lower_hold_r <= 2'h0;
         lower_hold_vld_r <= 1'b0;
      end
      else
      begin
         conv_r <= conv_nxt;
         lower_hold_r <= lower_hold_nxt;
         lower_hold_vld_r <= lower_hold_vld_nxt;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_signal_lost_live_r <= 1'b0;
         rx_signal_lost_sticky_r <= 1'b0;
      end
      else
      begin
         rx_signal_lost_live_r <= i_rx_signal_lost;
         rx_signal_lost_sticky_r <= rx_signal_lost_sticky_nxt;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rd_data_r <= osr_pkg::RST_BYTE;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= i_rd_en;
      end
   end

   assign o_rd_data = rd_data_r;
   assign o_rd_valid = rd_valid_r;
   assign o_tx_fault = fault_bus.tx_fault_flag;
   assign o_tx_driver_disabled = fault_bus.tx_driver_disabled_flag;
   assign o_rx_signal_lost_sticky = rx_signal_lost_sticky_r;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   upper_byte_read_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_UPPER)
      |=> (o_rd_data == $past(conv_r[9:2]) && o_rd_valid))
      else $error("upper converter byte read wrong");

   lower_rsvd_zero_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_LOWER) |=> (o_rd_data[7:2] == 6'h00))
      else $error("lower converter register upper bits not zero");

   live_los_bit_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_RX_STATUS)
      |=> (o_rd_data[5] == $past(i_rx_signal_lost, 2)))
      else $error("live loss bit does not follow input");

   sticky_los_set_a: assert property (
      (i_rx_signal_lost && !rx_signal_lost_live_r) ##1 !i_rx_signal_lost
      |-> o_rx_signal_lost_sticky)
      else $error("sticky loss bit not held after rise");

   sticky_los_clear_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_RX_STATUS && !los_rise)
      |=> !o_rx_signal_lost_sticky)
      else $error("sticky loss bit not cleared by read");

   tx_status_bits_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_TX_STATUS)
      |=> (o_rd_data[5] == $past(o_tx_fault) && o_rd_data[4] == $past(o_tx_driver_disabled)))
      else $error("transmit status bits wrong");

   drv_dis_hold_a: assert property (
      (o_tx_driver_disabled && !i_fault_clear) |=> o_tx_driver_disabled)
      else $error("driver disable dropped without clear");

   status_rsvd_zero_a: assert property (
      (i_rd_en && (i_rd_addr == osr_pkg::REG_RX_STATUS || i_rd_addr == osr_pkg::REG_TX_STATUS))
      |=> (o_rd_data[7:6] == 2'h0 && o_rd_data[3:0] == 4'h0))
      else $error("reserved status bits not zero");

   adj_read_zero_a: assert property (
      hit_adj |=> (o_rd_data == 8'h00))
      else $error("reserved adjustment register not zero");

   bias_fault_set_a: assert property (
      (i_digital_bias_monitor_select && i_bias_level >= i_bias_fault_threshold)
      |=> o_tx_fault)
      else $error("bias fault not flagged");

   pd_fault_set_a: assert property (
      (i_digital_photodiode_monitor_select && i_pd_level >= i_power_fault_threshold)
      |=> o_tx_fault)
      else $error("photodiode fault not flagged");

   coherent_lower_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_UPPER)
      ##1 (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_LOWER)
      |=> (o_rd_data[1:0] == $past(conv_r[1:0], 2)))
      else $error("lower bits not from same conversion");

   coherent_gap_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_UPPER)
      ##1 !(i_rd_en && (i_rd_addr == osr_pkg::REG_CONV_UPPER
                        || i_rd_addr == osr_pkg::REG_CONV_LOWER))
      ##1 (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_LOWER)
      |=> (o_rd_data[1:0] == $past(conv_r[1:0], 3)))
      else $error("lower bits not from conversion of upper read");

   capture_whole_a: assert property (
      i_conv_valid |=> (conv_r == $past(i_conv_result)))
      else $error("converter word not captured whole");

   freeze_release_a: assert property (
      (i_rd_en && i_rd_addr == osr_pkg::REG_CONV_LOWER) |=> !lower_hold_vld_r)
      else $error("low bit freeze not released by lower read");

   live_los_track_a: assert property (
      $past(i_nrst) |-> (rx_signal_lost_live_r == $past(i_rx_signal_lost)))
      else $error("live loss state does not follow input");

   sticky_los_hold_a: assert property (
      (o_rx_signal_lost_sticky && !(i_rd_en && i_rd_addr == osr_pkg::REG_RX_STATUS))
      |=> o_rx_signal_lost_sticky)
      else $error("sticky loss bit dropped without a read");

   sticky_set_wins_a: assert property (
      los_rise |=> o_rx_signal_lost_sticky)
      else $error("sticky loss bit not set on rise");

   tx_fault_clear_a: assert property (
      (i_fault_clear && !fault_bus.fault_detect) |=> !o_tx_fault)
      else $error("transmit fault not cleared");

   drv_dis_clear_a: assert property (
      (i_fault_clear && !fault_bus.fault_detect) |=> !o_tx_driver_disabled)
      else $error("driver disable not released");

   no_monitor_quiet_a: assert property (
      (!i_digital_bias_monitor_select && !i_digital_photodiode_monitor_select && !o_tx_fault)
      |=> !o_tx_fault)
      else $error("transmit fault raised with no monitor selected");
endmodule

// ==== osr_host_model.sv ====
// host read model driving the register read port
`timescale 1ns/100ps
module osr_host_model (
   input wire logic i_core_clk,
   output logic o_rd_en,
   output logic [5:0] o_rd_addr,
   input wire logic i_rd_valid,
   input wire logic [7:0] i_rd_data
);
   initial
   begin
      o_rd_en = 1'b0;
      o_rd_addr = 6'h3f;
   end

   // one read: request held up to the taken edge, data taken with valid
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      int n;
      @(posedge i_core_clk);
      o_rd_en <= 1'b1;
      o_rd_addr <= a;
      @(posedge i_core_clk);
      o_rd_en <= 1'b0;
      o_rd_addr <= ~a;
      #1;
      n = 0;
      while (i_rd_valid !== 1'b1 && n < 4)
      begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      // the answer is due on the first edge after the request, no later
      d = (i_rd_valid === 1'b1 && n == 0) ? i_rd_data : 8'hxx;
   endtask

   // two reads on consecutive edges, each answer taken the cycle after its request
   task automatic rd2(input logic [5:0] a0, input logic [5:0] a1,
                      output logic [7:0] d0, output logic [7:0] d1);
      @(posedge i_core_clk);
      o_rd_en <= 1'b1;
      o_rd_addr <= a0;
      @(posedge i_core_clk);
      o_rd_addr <= a1;
      #1;
      d0 = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
      @(posedge i_core_clk);
      o_rd_en <= 1'b0;
      o_rd_addr <= ~a1;
      #1;
      d1 = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
   endtask
endmodule

// ==== status_readback_registers_tb.sv ====
// self-checking bench for the status readback register group
`timescale 1ns/100ps
module status_readback_registers_tb;
   logic i_core_clk, i_nrst, rd_en, rd_valid, conv_valid, rx_lost;
   logic [5:0] rd_addr;
   logic [7:0] rd_data, bias, pd, bthr, pthr, d, d2;
   logic [9:0] conv;
   logic bsel, psel, fclr, tx_fault, tx_dis, sticky;
   int n_errors = 0;
   int tests_run = 0;

   osr_status_regs u_osr_status_regs (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
      .i_conv_valid(conv_valid), .i_conv_result(conv), .i_rx_signal_lost(rx_lost),
      .i_bias_level(bias), .i_pd_level(pd), .i_bias_fault_threshold(bthr),
      .i_power_fault_threshold(pthr), .i_digital_bias_monitor_select(bsel),
      .i_digital_photodiode_monitor_select(psel), .i_fault_clear(fclr),
      .o_tx_fault(tx_fault), .o_tx_driver_disabled(tx_dis),
      .o_rx_signal_lost_sticky(sticky));
   osr_host_model u_osr_host_model (.i_core_clk(i_core_clk), .o_rd_en(rd_en),
      .o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data));

   initial
   begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
      u_osr_host_model.rd(a, d);
      chk(d, exp);
   endtask

   task automatic test_reset_values();
      rdchk(osr_pkg::REG_CONV_UPPER, 8'h00);
      rdchk(osr_pkg::REG_CONV_LOWER, 8'h00);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h00);
      rdchk(osr_pkg::REG_TX_STATUS, 8'h00);
      $display("test reset values done");
   endtask

   task automatic test_converter();
      @(posedge i_core_clk);
      conv_valid <= 1'b1;
      conv <= 10'h2b5;
      @(posedge i_core_clk);
      conv_valid <= 1'b0;
      rdchk(osr_pkg::REG_CONV_UPPER, 8'had);
      @(posedge i_core_clk);
      conv_valid <= 1'b1;
      conv <= 10'h0f2;
      @(posedge i_core_clk);
      conv_valid <= 1'b0;
      rdchk(osr_pkg::REG_RX_STATUS, 8'h00);
      rdchk(osr_pkg::REG_CONV_LOWER, 8'h01);
      rdchk(osr_pkg::REG_CONV_UPPER, 8'h3c);
      rdchk(osr_pkg::REG_CONV_LOWER, 8'h02);
      @(posedge i_core_clk);
      conv_valid <= 1'b1;
      conv <= 10'h1c7;
      @(posedge i_core_clk);
      conv_valid <= 1'b0;
      u_osr_host_model.rd2(osr_pkg::REG_CONV_UPPER, osr_pkg::REG_CONV_LOWER, d, d2);
      chk(d, 8'h71);
      chk(d2, 8'h03);
      $display("test converter done");
   endtask

   task automatic test_rx_loss();
      @(posedge i_core_clk);
      rx_lost <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h30);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h20);
      chk({7'h00, sticky}, 8'h00);
      @(posedge i_core_clk);
      rx_lost <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h00);
      @(posedge i_core_clk);
      rx_lost <= 1'b1;
      @(posedge i_core_clk);
      rx_lost <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      chk({7'h00, sticky}, 8'h01);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h10);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h00);
      // rise lands on the same edge as a read: the set must win
      fork
         u_osr_host_model.rd(osr_pkg::REG_RX_STATUS, d);
         begin
            @(posedge i_core_clk);
            rx_lost <= 1'b1;
         end
      join
      chk(d, 8'h00);
      chk({7'h00, sticky}, 8'h01);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h30);
      @(posedge i_core_clk);
      rx_lost <= 1'b0;
      $display("test receive loss done");
   endtask

   task automatic test_tx_fault(input logic use_pd);
      @(posedge i_core_clk);
      bsel <= ~use_pd;
      psel <= use_pd;
      bias <= 8'h80;
      pd <= 8'h40;
      bthr <= 8'h81;
      pthr <= 8'h41;
      repeat (3) @(posedge i_core_clk);
      rdchk(osr_pkg::REG_TX_STATUS, 8'h00);
      @(posedge i_core_clk);
      bthr <= 8'h80;
      pthr <= 8'h40;
      repeat (2) @(posedge i_core_clk);
      #1;
      chk({6'h00, tx_fault, tx_dis}, 8'h03);
      rdchk(osr_pkg::REG_TX_STATUS, 8'h30);
      rdchk(osr_pkg::REG_TX_STATUS, 8'h30);
      @(posedge i_core_clk);
      bthr <= 8'hff;
      pthr <= 8'hff;
      fclr <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      fclr <= 1'b0;
      rdchk(osr_pkg::REG_TX_STATUS, 8'h00);
      $display("test transmit fault done");
   endtask

   task automatic test_reserved();
      rdchk(osr_pkg::REG_ADJ_FIRST, 8'h00);
      rdchk(osr_pkg::REG_ADJ_LAST, 8'h00);
      rdchk(6'h3f, 8'h00);
      $display("test reserved done");
   endtask

   task automatic test_mid_reset();
      @(posedge i_core_clk);
      bsel <= 1'b1;
      bthr <= 8'h00;
      rx_lost <= 1'b1;
      @(posedge i_core_clk);
      rx_lost <= 1'b0;
      bsel <= 1'b0;
      bthr <= 8'hff;
      #1;
      chk({6'h00, tx_fault, sticky}, 8'h03);
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk({5'h00, tx_fault, tx_dis, sticky}, 8'h00);
      @(posedge i_core_clk);
      i_nrst <= 1'b1;
      rdchk(osr_pkg::REG_TX_STATUS, 8'h00);
      rdchk(osr_pkg::REG_RX_STATUS, 8'h00);
      $display("test mid-run reset done");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      i_nrst = 1'b0;
      {conv_valid, rx_lost, bsel, psel, fclr} = 5'h00;
      conv = 10'h000;
      {bias, pd} = 16'h0000;
      {bthr, pthr} = 16'hffff;
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      test_reset_values();
      test_converter();
      test_rx_loss();
      test_tx_fault(1'b0);
      test_tx_fault(1'b1);
      test_mid_reset();
      test_reserved();
      report_and_stop();
   end

   initial
   begin
      #(100 * 3000);
      n_errors++;
      report_and_stop();
   end
endmodule
